// ### hdl/icc_pkg.sv
// constants shared by the input capture channel files
package icc_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BUF_OFS  = 8'h04;
   localparam int         ADR_W    = 8;
   localparam int         DAT_W    = 32;
   localparam int         TMR_W    = 16;

   // ==========================================
   // control register fields
   localparam int BIT_ON    = 15;
   localparam int BIT_FRZ   = 14;
   localparam int BIT_STOP_IN_IDLE  = 13;
   localparam int BIT_FEDGE = 9;
   localparam int BIT_C32   = 8;
   localparam int BIT_TMR   = 7;
   localparam int BIT_ICI_H = 6;
   localparam int BIT_ICI_L = 5;
   localparam int BIT_OV    = 4;
   localparam int BIT_BNE   = 3;
   localparam int BIT_ICM_H = 2;
   localparam int BIT_ICM_L = 0;

   // writable bits of the control register, reset value
   localparam logic [31:0] CTRL_WMASK = 32'h0000_e3e7;
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

   // ==========================================
   // capture mode field encodings
   localparam logic [2:0] MODE_OFF   = 3'h0;
   localparam logic [2:0] MODE_EDGE  = 3'h1;
   localparam logic [2:0] MODE_FALL  = 3'h2;
   localparam logic [2:0] MODE_RISE  = 3'h3;
   localparam logic [2:0] MODE_PRE4  = 3'h4;
   localparam logic [2:0] MODE_PRE16 = 3'h5;
   localparam logic [2:0] MODE_EVERY = 3'h6;
   localparam logic [2:0] MODE_WAKE  = 3'h7;

   // ==========================================
   // prescaler terminal counts (edges minus one)
   localparam logic [3:0] PRE4_LAST  = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hf;
endpackage : icc_pkg

// ### hdl/icc_edge_sync.sv
// three-stage input synchroniser with rise and fall detection
`timescale 1ns/1ps
module icc_edge_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // asynchronous pin
   input  wire logic pin_i,
   // synchronised edges
   output logic      rise_o,
   output logic      fall_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;
   wire  agree;

   // a change counts once stages two and three agree
   assign agree  = (s2_reg == s3_reg);
   assign rise_o = agree & s3_reg & ~lvl_reg;
   assign fall_o = agree & ~s3_reg & lvl_reg;

   // shift chain; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         lvl_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (agree) begin
            lvl_reg <= s3_reg;
         end
      end
   end
endmodule : icc_edge_sync

// ### hdl/icc_channel.sv
// input capture channel with four-entry capture queue and wishbone slave
//
// Summary of operation
// - timer select: 0 third timer, 1 second
// - wide bit captures paired 32-bit count
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 110 every edge, first per polarity
// - simple modes bypass the prescaler
// - input synchronised; count latched after delay
// - interrupt after one to four captures
// - modes 100/101 capture every 4th/16th rise
// - mode change keeps prescaler count
// - mode 001 captures both edges, no prescaler
// - edge detect leaves overflow flag alone
// - edge detect interrupts on every capture
// - mode 111 in sleep: rise interrupts
// - interrupt-only mode never touches buffer
// - wake interrupt drops on leaving sleep
// - wake mode ignores select, count, prescaler
// - not-empty flag shows unread captures
// - overflow flag set on capture overflow
// - mode 000 disables capturing
// - buffer read returns captured count
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module icc_channel #(
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   // wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [icc_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [icc_pkg::DAT_W-1:0]  wb_dat_i,
   output logic      [icc_pkg::DAT_W-1:0]  wb_dat_o,
   output logic                            wb_ack_o,
   // capture pin and time bases
   input  wire logic                       capture_in_i,
   input  wire logic [icc_pkg::TMR_W-1:0]  second_timer_i,
   input  wire logic [icc_pkg::TMR_W-1:0]  third_timer_i,
   // device power and debug state
   input  wire logic                       low_power_i,
   input  wire logic                       idle_i,
   input  wire logic                       debug_i,
   // capture interrupt event
   output logic                            irq_o
);
   localparam int PW = $clog2(DEPTH);

   // ==========================================
   // declarations
   logic [icc_pkg::DAT_W-1:0] ctrl_reg;
   logic [icc_pkg::DAT_W-1:0] ctrl_next;
   logic [icc_pkg::DAT_W-1:0] fifo_reg [DEPTH];
   logic [PW-1:0]             rd_ptr_reg;
   logic [PW-1:0]             wr_ptr_reg;
   logic [PW:0]               cnt_reg;
   logic                      ov_reg;
   logic [3:0]                pre_reg;
   logic [1:0]                ici_cnt_reg;
   logic                      first_done_reg;
   logic [2:0]                mode_last_reg;
   logic                      irq_reg;
   logic                      ack_reg;
   logic [icc_pkg::DAT_W-1:0] dat_reg;
   logic                      rise;
   logic                      fall;

   // ==========================================
   // synchroniser for the capture pin
   icc_edge_sync u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (capture_in_i),
      .rise_o (rise),
      .fall_o (fall)
   );

   // ==========================================
   // control field decode
   wire       on_bit  = ctrl_reg[icc_pkg::BIT_ON];
   wire       frz_bit = ctrl_reg[icc_pkg::BIT_FRZ];
   wire       stop_in_idle    = ctrl_reg[icc_pkg::BIT_STOP_IN_IDLE];
   wire       fedge   = ctrl_reg[icc_pkg::BIT_FEDGE];
   wire       c32     = ctrl_reg[icc_pkg::BIT_C32];
   wire       tsel    = ctrl_reg[icc_pkg::BIT_TMR];
   wire [1:0] captures_per_interrupt     = ctrl_reg[icc_pkg::BIT_ICI_H:icc_pkg::BIT_ICI_L];
   wire [2:0] mode    = ctrl_reg[icc_pkg::BIT_ICM_H:icc_pkg::BIT_ICM_L];

   // module halted by freeze in debug or stop in idle
   wire halted = (frz_bit & debug_i) | (stop_in_idle & idle_i);
   wire run    = on_bit & ~halted;

   // mode decode
   wire m_edge  = (mode == icc_pkg::MODE_EDGE);
   wire m_fall  = (mode == icc_pkg::MODE_FALL);
   wire m_rise  = (mode == icc_pkg::MODE_RISE);
   wire m_pre4  = (mode == icc_pkg::MODE_PRE4);
   wire m_pre16 = (mode == icc_pkg::MODE_PRE16);
   wire m_every = (mode == icc_pkg::MODE_EVERY);
   wire m_wake  = (mode == icc_pkg::MODE_WAKE);
   wire m_pre   = m_pre4 | m_pre16;

   // ==========================================
   // capture source selection
   wire [icc_pkg::TMR_W-1:0] tmr16 = tsel ? second_timer_i : third_timer_i;
   wire [icc_pkg::DAT_W-1:0] tval  = c32 ? {third_timer_i, second_timer_i}
                                         : {{icc_pkg::TMR_W{1'b0}}, tmr16};

   // ==========================================
   // capture triggers per mode
   wire [3:0] pre_last = m_pre16 ? icc_pkg::PRE16_LAST : icc_pkg::PRE4_LAST;
   wire pre_hit  = m_pre & rise & (pre_reg >= pre_last);
   wire first_ok = fedge ? rise : fall;
   wire every_hit = m_every & (first_done_reg ? (rise | fall) : first_ok);
   // simple and edge modes take edges directly, prescaler bypassed
   wire simple_hit = (m_rise & rise)
                   | (m_fall & fall)
                   | (m_edge & (rise | fall))
                   | every_hit;
   // mode 000 and wake mode never capture
   wire cap = run & (simple_hit | pre_hit);

   // ==========================================
   // queue status and bus decode
   wire full   = (cnt_reg == (PW + 1)'(DEPTH));
   wire empty  = (cnt_reg == '0);
   wire push   = cap & ~full;
   wire ovf    = cap & full & ~m_edge;
   wire req    = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire hit_c  = (wb_adr_i == icc_pkg::CTRL_OFS);
   wire hit_b  = (wb_adr_i == icc_pkg::BUF_OFS);
   wire wr_c   = req & wb_we_i & hit_c;
   wire pop    = req & ~wb_we_i & hit_b & ~empty;

   // byte-enabled write mask restricted to writable bits
   wire [31:0] be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & icc_pkg::CTRL_WMASK;

   // control register read view with live status bits
   wire [31:0] ctrl_view = (ctrl_reg & icc_pkg::CTRL_WMASK)
                         | ({31'h0000_0000, ov_reg} << icc_pkg::BIT_OV)
                         | ({31'h0000_0000, ~empty} << icc_pkg::BIT_BNE);

   // read data mux; unmapped addresses read zero
   wire [31:0] rd_mux = hit_c ? ctrl_view
                      : (hit_b & ~empty) ? fifo_reg[rd_ptr_reg]
                      : 32'h0000_0000;

   // interrupt event: every capture in edge mode, else per count
   wire ici_done = (ici_cnt_reg == captures_per_interrupt);
   wire cap_irq  = cap & (m_edge | ici_done);
   // wake interrupt only while the device sleeps (low_power_i), not in idle
   wire wake_hit = on_bit & m_wake & low_power_i & rise;

   // ==========================================
   // control register next value
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_c) begin
         ctrl_next = (ctrl_reg & ~be_mask) | (wb_dat_i & be_mask);
      end
   end

   // control register and bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= icc_pkg::CTRL_RST;
         ack_reg  <= 1'b0;
         dat_reg  <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         ack_reg  <= req;
         if (req & ~wb_we_i) begin
            dat_reg <= rd_mux;
         end
      end
   end

   // ==========================================
   // capture queue storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            fifo_reg[i] <= 32'h0000_0000;
         end
      end else if (push) begin
         fifo_reg[wr_ptr_reg] <= tval;
      end
   end

   // queue pointers and fill count; disabling the module flushes it
   always_ff @(posedge clk_i) begin
      if (rst_i || !on_bit) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         cnt_reg    <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + PW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + PW'(1);
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + (PW + 1)'(1);
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - (PW + 1)'(1);
         end
      end
   end

   // overflow flag: sticky until the module is disabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_reg <= 1'b0;
      end else if (ovf) begin
         ov_reg <= 1'b1;
      end else if (!on_bit) begin
         ov_reg <= 1'b0;
      end
   end

   // ==========================================
   // prescaler: cleared by disabling or at its terminal count, not by a mode change
   always_ff @(posedge clk_i) begin
      if (rst_i || !on_bit) begin
         pre_reg <= 4'h0;
      end else if (run && m_pre && rise) begin
         if (pre_hit) begin
            pre_reg <= 4'h0;
         end else begin
            pre_reg <= pre_reg + 4'h1;
         end
      end
   end

   // first-edge tracking for every-edge mode; rearms on mode change
   always_ff @(posedge clk_i) begin
      if (rst_i || !on_bit) begin
         first_done_reg <= 1'b0;
         mode_last_reg  <= icc_pkg::MODE_OFF;
      end else begin
         mode_last_reg <= mode;
         if (mode != mode_last_reg) begin
            first_done_reg <= 1'b0;
         end else if (run && every_hit) begin
            first_done_reg <= 1'b1;
         end
      end
   end

   // captures-per-interrupt counter
   always_ff @(posedge clk_i) begin
      if (rst_i || !on_bit) begin
         ici_cnt_reg <= 2'h0;
      end else if (cap && !m_edge) begin
         if (ici_done) begin
            ici_cnt_reg <= 2'h0;
         end else begin
            ici_cnt_reg <= ici_cnt_reg + 2'h1;
         end
      end
   end

   // ==========================================
   // interrupt output: one-cycle event, wake level held during sleep
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else if (cap_irq || wake_hit) begin
         irq_reg <= 1'b1;
      end else if (irq_reg && m_wake && on_bit && low_power_i) begin
         irq_reg <= 1'b1;
      end else begin
         irq_reg <= 1'b0;
      end
   end

   // ==========================================
   // outputs straight from flip-flops
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_o    = irq_reg;
endmodule : icc_channel

// ### verification/icc_far_model.sv
// far-side model: free-running time bases and capture pin
`timescale 1ns/1ps
module icc_far_model #(
   parameter logic [15:0] T3_INIT = 16'h5a00
) (
   // clock and reset
   input  logic        clk_i,
   input  logic        rst_i,
   // time bases and pin
   output logic [15:0] second_timer_o,
   output logic [15:0] third_timer_o,
   output logic        capture_o
);
   // ==========
   // time bases step every clock at two rates
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         second_timer_o <= 16'h0000;
         third_timer_o  <= T3_INIT;
      end else begin
         second_timer_o <= second_timer_o + 16'h0001;
         third_timer_o  <= third_timer_o + 16'h0103;
      end
   end
   // pin level, changed only right after an edge
   initial capture_o = 1'b0;
   task automatic drive(input logic lvl);
      capture_o <= lvl;
   endtask : drive
endmodule : icc_far_model

// ### verification/icc_channel_props.sv
// assertion checker on the capture channel ports
`timescale 1ns/1ps
module icc_channel_props #(
   parameter int DEPTH = 4
) (
   // clock and reset
   input logic        clk_i,
   input logic        rst_i,
   // bus
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [7:0]  wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   // pins
   input logic        capture_in_i,
   input logic [15:0] second_timer_i,
   input logic [15:0] third_timer_i,
   input logic        low_power_i,
   input logic        idle_i,
   input logic        debug_i,
   input logic        irq_o
);
   // ==========
   // shadow of control bits, pin history
   logic [15:0] ctl_reg;
   logic [4:0]  hist_reg;
   logic        pin_reg;
   logic [3:0]  off_reg;
   wire  [15:0] wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & 16'he3e7;
   wire         req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & (wb_adr_i == 8'h00);
   wire  [2:0]  mode    = ctl_reg[2:0];
   // track writes, pin changes, quiet time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg  <= '0;
         hist_reg <= '0;
         pin_reg  <= 1'b0;
         off_reg  <= '0;
      end else begin
         if (req && wb_we_i) ctl_reg <= (ctl_reg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask);
         hist_reg <= {hist_reg[3:0], capture_in_i ^ pin_reg};
         pin_reg  <= capture_in_i;
         off_reg  <= (mode != 3'h0) ? 4'h0 : off_reg + {3'h0, off_reg != 4'hf};
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   a_ctrl_readback: assert property (req && !wb_we_i |=>
      (wb_dat_o & 32'h0000_e3e7) == {16'h0, ctl_reg}) else $error("bad control read");
   a_irq_pulse: assert property (mode != 3'h7 && $past(mode) != 3'h7 && irq_o |=> !irq_o)
      else $error("irq not a pulse");
   a_wake_hold: assert property (mode == 3'h7 && irq_o && low_power_i |=> irq_o || !low_power_i)
      else $error("wake irq lost");
   a_wake_drop: assert property (mode == 3'h7 && $fell(low_power_i) |=> !irq_o)
      else $error("wake irq stuck");
   a_irq_after_pin: assert property ($rose(irq_o) |-> |hist_reg[4:2])
      else $error("irq without pin edge");
   a_off_quiet: assert property (off_reg > 4'h6 |-> !irq_o)
      else $error("irq while off");
endmodule : icc_channel_props

bind icc_channel icc_channel_props #(.DEPTH(DEPTH)) u_icc_channel_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_in_i(capture_in_i),
   .second_timer_i(second_timer_i), .third_timer_i(third_timer_i),
   .low_power_i(low_power_i), .idle_i(idle_i), .debug_i(debug_i), .irq_o(irq_o));

// ### verification/testbench.sv
// self-checking bench for the capture channel
`timescale 1ns/1ps
module testbench;
   // ==========
   // stimulus and model state
   logic        clk_i, rst_i, cyc, stb, we, lp, dbg;
   logic        ack, irq, pin, ov, armed, wake;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, r;
   logic [15:0] t2, t3, ctl;
   int          n_fail, tests_run, seed, pre, icnt;
   logic [31:0] q[$];
   logic [31:0] tbl[9] = '{32'h000a_0083, 32'h0006_0022, 32'h0006_0106, 32'h000c_0061,
      32'h000a_0004, 32'h041e_0005, 32'h0204_4003, 32'h0104_00e7, 32'h0004_0200};

   icc_channel #(.DEPTH(4)) u_icc_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .capture_in_i(pin), .second_timer_i(t2),
      .third_timer_i(t3), .low_power_i(lp), .idle_i(1'b0), .debug_i(dbg), .irq_o(irq));
   icc_far_model u_icc_far_model (.clk_i(clk_i), .rst_i(rst_i), .second_timer_o(t2),
      .third_timer_o(t3), .capture_o(pin));

   // clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t word %h exp %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t irq %b exp %b", $time, g, e);
      end
   endtask : chk_bit
   // one classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] o);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         final_report();
      end
      o = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // one pin edge, model capture, check irq
   task automatic step();
      logic rise, cap, ie;
      logic [31:0] v;
      rise = !pin;
      cap = 1'b0;
      ie = 1'b0;
      @(posedge clk_i);
      u_icc_far_model.drive(rise);
      repeat (3) @(posedge clk_i);
      #1;
      v = ctl[8] ? {t3, t2} : {16'h0, ctl[7] ? t2 : t3};
      if (ctl[15] && !(ctl[14] && dbg)) begin
         case (ctl[2:0])
            3'h1: cap = 1'b1;
            3'h2: cap = !rise;
            3'h3: cap = rise;
            3'h6: cap = armed | (rise == ctl[9]);
            3'h7: wake = wake | (rise & lp);
            default: if (rise && ctl[2]) begin
               cap = (pre == (ctl[0] ? 15 : 3));
               pre = cap ? 0 : pre + 1;
            end
         endcase
      end
      armed = armed | cap;
      if (cap) begin
         if (q.size() < 4) q.push_back(v);
         else if (ctl[2:0] != 3'h1) ov = 1'b1;
         icnt++;
         ie = (ctl[2:0] == 3'h1 || icnt > ctl[6:5]);
         if (ie) icnt = 0;
      end
      @(posedge clk_i);
      #1;
      chk_bit(irq, ie | wake);
      repeat ($unsigned($random(seed)) % 3) @(posedge clk_i);
   endtask : step
   // one table entry: set up, run edges, read back
   task automatic run(input logic [31:0] e);
      if (!e[26]) begin
         wb(1'b1, 8'h00, 32'h0, r);
         q.delete();
         {ov, pre, icnt} = '0;
      end
      lp <= e[24];
      dbg <= e[25];
      ctl = e[15:0] | 16'h8000;
      wb(1'b1, 8'h00, {16'h0, ctl}, r);
      {armed, wake} = '0;
      repeat (e[23:16]) step();
      wb(1'b0, 8'h00, 32'h0, r);
      chk_word(r, {16'h0, ctl & 16'he3e7, 16'h0} >> 16 | {ov, q.size() != 0, 3'h0});
      while (q.size() != 0) begin
         wb(1'b0, 8'h04, 32'h0, r);
         chk_word(r, q.pop_front());
      end
      wb(1'b0, 8'h04, 32'h0, r);
      chk_word(r, 32'h0);
      lp <= 1'b0;
      dbg <= 1'b0;
      @(posedge clk_i);
      #1;
      chk_bit(irq, 1'b0);
   endtask : run

   task automatic final_report();
      $display("fails %0d checks %0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      {cyc, stb, we, lp, dbg} = '0;
      adr = '0;
      wdat = '0;
      seed = 32'h92ba;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h04, 32'h1234_5678, r);
      wb(1'b0, 8'h04, 32'h0, r);
      chk_word(r, 32'h0);
      wb(1'b0, 8'h40, 32'h0, r);
      chk_word(r, 32'h0);
      foreach (tbl[i]) run(tbl[i]);
      final_report();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      final_report();
   end
endmodule : testbench
